// file: verilog/css_regs.svh
// register map, field positions and save-area layout constants
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH
// word indices, byte address is index times four
`define CSS_IDX_CTRL 4'h0
`define CSS_IDX_CMD 4'h1
`define CSS_IDX_SIMDCS 4'h2
`define CSS_IDX_IMASK_LO 4'h3
`define CSS_IDX_IMASK_HI 4'h4
`define CSS_IDX_UEN_LO 4'h5
`define CSS_IDX_UEN_HI 4'h6
`define CSS_IDX_SEN_LO 4'h7
`define CSS_IDX_SEN_HI 4'h8
`define CSS_IDX_AREA_LO 4'h9
`define CSS_IDX_AREA_HI 4'hA
`define CSS_IDX_INUSE_LO 4'hB
`define CSS_IDX_INUSE_HI 4'hC
`define CSS_IDX_MOD_LO 4'hD
`define CSS_IDX_MOD_HI 4'hE
`define CSS_IDX_STATUS 4'hF
// control word fields
`define CSS_CTRL_OSE 0
`define CSS_CTRL_TS 3
`define CSS_CTRL_AM 4
`define CSS_CTRL_AC 5
`define CSS_CTRL_PRIV_LSB 8
`define CSS_CTRL_NR 10
// command word fields
`define CSS_CMD_GO 0
`define CSS_CMD_SUP 1
// status word fields
`define CSS_STS_BUSY 0
`define CSS_STS_DONE 1
`define CSS_STS_FLT_LSB 4
// values
`define CSS_SIMDCS_INIT 32'h0000_1F80
`define CSS_SIMDCS_MASK 32'h0000_FFFF
`define CSS_PRIV_USER 2'h3
`define CSS_PRIV_SUPER 2'h0
`define CSS_RESP_OK 2'h0
`define CSS_RESP_ERR 2'h2
// save-area layout, byte offsets from the area base
`define CSS_OFF_PRES 64'h0000_0000_0000_0200
`define CSS_OFF_COMP 64'h0000_0000_0000_0208
`define CSS_OFF_LEG1 64'h0000_0000_0000_00A0
`define CSS_OFF_SIMDCS 64'h0000_0000_0000_0018
`define CSS_OFF_EXT 64'h0000_0000_0000_0240
`define CSS_SLOT_SHIFT 6
`define CSS_ALIGN_MSB 5
`define CSS_COMP_EXT 6'h02
`define CSS_COMP_LAST 6'h3E
`define CSS_COMP_SSE 6'h01
`endif

// file: verilog/css_pkg.sv
// types shared by the compacted state save unit
package css_pkg;
    typedef enum logic [2:0] {
        FLT_NONE, FLT_UD, FLT_NM, FLT_GP, FLT_AC
    } fault_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_HDRC, ST_SCAN, ST_FETCH, ST_SIMDCS, ST_WAIT
    } state_e;
    typedef struct packed {
        logic [63:0] addr;
        logic [63:0] data;
    } mem_wr_s;
    typedef struct packed {
        logic [1:0] priv;
        logic nonRoot;
        logic [63:0] addr;
        logic [63:0] comp;
    } restore_s;
endpackage : css_pkg

// file: verilog/compacted_state_save_unit.sv
// compacted and supervisor compacted state save execution unit
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`include "css_regs.svh"
// Function
// - user mask is user enable AND instruction mask
// - save enable clear gives invalid opcode fault
// - task switched bit set gives device fault
// - misaligned save area gives protection fault
// - supervisor save above level zero faults
// - alignment check fault may replace misalignment
// - presence field written, unrequested bits zero
// - presence bit follows in-use bitmap
// - dirty simd status forces presence bit one
// - compaction field: bit 63 set, mask below
// - no other header location written
// - presence field never read first
// - components 0,1 legacy, others compacted extended
// - init optimization skips unused components
// - dirty simd status stores whole component one
// - mask bit 2 ignored for simd status
// - user save never uses modified optimization
// - supervisor mask uses both enable registers
// - modified optimization needs matching restore record
// - modified optimization skips unmodified components
// - each restore records the last-restore tuple
module compacted_state_save_unit (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // axi4-lite register slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // save-area memory write port
    output logic memWrValid,
    output css_pkg::mem_wr_s memWr,
    input wire logic memWrReady,
    // component state read from the core
    output logic [5:0] stateIdx,
    input wire logic [63:0] stateData,
    // restore record update from the restore unit
    input wire logic restoreValid,
    input wire css_pkg::restore_s restoreInfo,
    // fault report
    output logic faultPulse,
    output css_pkg::fault_e faultCode
);
    import css_pkg::*;

    logic [31:0] word_reg [0:15];
    logic goReq_reg, supReq_reg, doneFlag_reg, modOpt_reg;
    logic [63:0] reqMask_reg, area_reg;
    logic [5:0] idx_reg;
    state_e st_reg, ret_reg;
    restore_s rec_reg;

    // merge written bytes into a register word
    function automatic logic [31:0] applyStrb(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : applyStrb

    // compacted byte offset of extended component idx
    function automatic logic [63:0] extOffset(input logic [63:0] mask,
        input logic [5:0] idx);
        logic [63:0] cnt;
        cnt = 64'h0;
        for (int j = 2; j < 63; j++) begin
            if (j < int'(idx) && mask[j]) begin
                cnt = cnt + 64'h1;
            end
        end
        return `CSS_OFF_EXT + (cnt << `CSS_SLOT_SHIFT);
    endfunction : extOffset

    // field views of the register words
    logic [31:0] ctrl;
    logic [1:0] priv;
    logic [63:0] iMask, uEn, sEn, area, inUse, modBits, reqMask;
    logic mxDirty, misAlign, modOpt, needStore;
    fault_e fault;
    assign ctrl = word_reg[`CSS_IDX_CTRL];
    assign priv = ctrl[`CSS_CTRL_PRIV_LSB +: 2];
    assign iMask = {word_reg[`CSS_IDX_IMASK_HI], word_reg[`CSS_IDX_IMASK_LO]};
    assign uEn = {word_reg[`CSS_IDX_UEN_HI], word_reg[`CSS_IDX_UEN_LO]};
    assign sEn = {word_reg[`CSS_IDX_SEN_HI], word_reg[`CSS_IDX_SEN_LO]};
    assign area = {word_reg[`CSS_IDX_AREA_HI], word_reg[`CSS_IDX_AREA_LO]};
    assign inUse = {word_reg[`CSS_IDX_INUSE_HI], word_reg[`CSS_IDX_INUSE_LO]};
    assign modBits = {word_reg[`CSS_IDX_MOD_HI], word_reg[`CSS_IDX_MOD_LO]};
    assign mxDirty = word_reg[`CSS_IDX_SIMDCS] != `CSS_SIMDCS_INIT;
    assign misAlign = area[`CSS_ALIGN_MSB:0] != '0;

    // requested component mask per save form
    assign reqMask = supReq_reg ? (iMask & (uEn | sEn))
                             : (iMask & uEn);

    // fault checks in priority order
    always_comb begin
        fault = FLT_NONE;
        if (!ctrl[`CSS_CTRL_OSE]) begin
            fault = FLT_UD;
        end else if (ctrl[`CSS_CTRL_TS]) begin
            fault = FLT_NM;
        end else if (supReq_reg && priv != `CSS_PRIV_SUPER) begin
            fault = FLT_GP;
        end else if (misAlign) begin
            fault = FLT_GP;
            if (!supReq_reg && ctrl[`CSS_CTRL_AM] && ctrl[`CSS_CTRL_AC]
                && priv == `CSS_PRIV_USER) begin
                fault = FLT_AC;
            end
        end
    end

    // modified optimization only for supervisor with matching record
    assign modOpt = supReq_reg && rec_reg.priv == priv
        && rec_reg.nonRoot == ctrl[`CSS_CTRL_NR] && rec_reg.addr == area
        && rec_reg.comp[63] && rec_reg.comp[62:0] == reqMask[62:0];

    // store decision for the scanned component
    always_comb begin
        needStore = reqMask_reg[idx_reg] && (inUse[idx_reg]
            || (idx_reg == `CSS_COMP_SSE && mxDirty));
        if (modOpt_reg && !modBits[idx_reg]) begin
            needStore = 1'b0;
        end
    end

    // axi write channel and register words
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < 16; k++) begin
                word_reg[k] <= 32'h0;
            end
            word_reg[`CSS_IDX_SIMDCS] <= `CSS_SIMDCS_INIT;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSS_RESP_OK;
            goReq_reg <= 1'b0;
            supReq_reg <= 1'b0;
        end else if (ce) begin
            if (st_reg == ST_CHECK) begin
                goReq_reg <= 1'b0; // request taken
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (!s_axi_awready && s_axi_awvalid && s_axi_wvalid
                && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `CSS_RESP_OK;
                if (s_axi_awaddr[7:6] != 2'h0) begin
                    s_axi_bresp <= `CSS_RESP_ERR;
                end else if (s_axi_awaddr[5:2] == `CSS_IDX_CMD) begin
                    // start ignored while an instruction runs
                    if (st_reg == ST_IDLE && !goReq_reg && s_axi_wstrb[0]
                        && s_axi_wdata[`CSS_CMD_GO]) begin
                        goReq_reg <= 1'b1;
                        supReq_reg <= s_axi_wdata[`CSS_CMD_SUP];
                    end
                end else if (s_axi_awaddr[5:2] != `CSS_IDX_STATUS) begin
                    word_reg[s_axi_awaddr[5:2]] <= applyStrb(
                        word_reg[s_axi_awaddr[5:2]], s_axi_wdata,
                        s_axi_wstrb);
                end
            end else begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CSS_RESP_OK;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (!s_axi_arready && s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CSS_RESP_OK;
                s_axi_rdata <= 32'h0;
                if (s_axi_araddr[7:6] != 2'h0) begin
                    s_axi_rresp <= `CSS_RESP_ERR;
                end else if (s_axi_araddr[5:2] == `CSS_IDX_STATUS) begin
                    s_axi_rdata[`CSS_STS_BUSY] <= st_reg != ST_IDLE
                        || goReq_reg;
                    s_axi_rdata[`CSS_STS_DONE] <= doneFlag_reg;
                    s_axi_rdata[`CSS_STS_FLT_LSB +: 3] <= faultCode;
                end else if (s_axi_araddr[5:2] != `CSS_IDX_CMD) begin
                    s_axi_rdata <= word_reg[s_axi_araddr[5:2]];
                end
            end else begin
                s_axi_arready <= 1'b0;
            end
        end
    end

    // last-restore record capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rec_reg <= '0;
        end else if (ce && restoreValid) begin
            rec_reg <= restoreInfo;
        end
    end

    // save sequencer: checks, header, then components; no memory reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            idx_reg <= 6'h0;
            reqMask_reg <= 64'h0;
            area_reg <= 64'h0;
            modOpt_reg <= 1'b0;
            doneFlag_reg <= 1'b0;
            faultPulse <= 1'b0;
            faultCode <= FLT_NONE;
            memWrValid <= 1'b0;
            memWr <= '0;
            stateIdx <= 6'h0;
        end else if (ce) begin
            faultPulse <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (goReq_reg) begin
                        doneFlag_reg <= 1'b0;
                        st_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    faultCode <= fault;
                    if (fault != FLT_NONE) begin
                        faultPulse <= 1'b1;
                        doneFlag_reg <= 1'b1;
                        st_reg <= ST_IDLE;
                    end else begin
                        reqMask_reg <= reqMask;
                        area_reg <= area;
                        modOpt_reg <= modOpt;
                        memWr.addr <= area + `CSS_OFF_PRES;
                        memWr.data <= reqMask & (inUse
                            | {62'h0, mxDirty, 1'b0});
                        memWrValid <= 1'b1;
                        ret_reg <= ST_HDRC;
                        st_reg <= ST_WAIT;
                    end
                end
                ST_HDRC: begin
                    memWr.addr <= area_reg + `CSS_OFF_COMP;
                    memWr.data <= {1'b1, reqMask_reg[62:0]};
                    memWrValid <= 1'b1;
                    idx_reg <= 6'h0;
                    ret_reg <= ST_SCAN;
                    st_reg <= ST_WAIT;
                end
                ST_SCAN: begin
                    if (idx_reg > `CSS_COMP_LAST) begin
                        doneFlag_reg <= 1'b1;
                        st_reg <= ST_IDLE;
                    end else if (needStore) begin
                        stateIdx <= idx_reg;
                        // legacy region for 0 and 1
                        if (idx_reg < `CSS_COMP_EXT) begin
                            memWr.addr <= area_reg + (idx_reg[0]
                                ? `CSS_OFF_LEG1 : 64'h0);
                        end else begin
                            memWr.addr <= area_reg
                                + extOffset(reqMask_reg, idx_reg);
                        end
                        st_reg <= ST_FETCH;
                    end else begin
                        idx_reg <= idx_reg + 6'h1;
                    end
                end
                ST_FETCH: begin
                    memWr.data <= stateData;
                    memWrValid <= 1'b1;
                    // simd status rides with component 1 only
                    ret_reg <= (idx_reg == `CSS_COMP_SSE)
                        ? ST_SIMDCS : ST_SCAN;
                    idx_reg <= idx_reg + 6'h1;
                    st_reg <= ST_WAIT;
                end
                ST_SIMDCS: begin
                    memWr.addr <= area_reg + `CSS_OFF_SIMDCS;
                    memWr.data <= {`CSS_SIMDCS_MASK,
                        word_reg[`CSS_IDX_SIMDCS]};
                    memWrValid <= 1'b1;
                    ret_reg <= ST_SCAN;
                    st_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (memWrReady) begin
                        memWrValid <= 1'b0;
                        st_reg <= ret_reg;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_ud_fault: assert property (
        ce && st_reg == ST_CHECK && !ctrl[`CSS_CTRL_OSE]
        |=> faultPulse && faultCode == FLT_UD && !memWrValid)
        else $error("save enable clear did not give invalid opcode");
    chk_nm_fault: assert property (
        ce && st_reg == ST_CHECK && ctrl[`CSS_CTRL_OSE]
        && ctrl[`CSS_CTRL_TS] |=> faultPulse && faultCode == FLT_NM)
        else $error("task switched did not give device fault");
    chk_priv_gp: assert property (
        ce && st_reg == ST_CHECK && fault != FLT_UD && fault != FLT_NM
        && supReq_reg && priv != `CSS_PRIV_SUPER
        |=> faultCode == FLT_GP ##1 st_reg == ST_IDLE)
        else $error("supervisor save above level zero not faulted");
    chk_align_gp: assert property (
        ce && st_reg == ST_CHECK && misAlign
        |=> faultPulse && faultCode != FLT_NONE)
        else $error("misaligned area not faulted");
    chk_fault_nowrite: assert property (
        faultPulse |-> !memWrValid ##1 !memWrValid)
        else $error("memory write issued for faulting save");
    chk_comp_field: assert property (
        memWrValid && memWr.addr == area_reg + `CSS_OFF_COMP
        |-> memWr.data == {1'b1, reqMask_reg[62:0]})
        else $error("compaction field value wrong");
    chk_pres_field: assert property (
        memWrValid && memWr.addr == area_reg + `CSS_OFF_PRES
        |-> (memWr.data & ~reqMask_reg) == 64'h0)
        else $error("presence bit set for unrequested component");
    chk_init_skip: assert property (
        ce && st_reg == ST_SCAN && idx_reg <= `CSS_COMP_LAST
        && !inUse[idx_reg] && idx_reg != `CSS_COMP_SSE
        |=> st_reg != ST_FETCH)
        else $error("unused component stored");
    chk_mod_skip: assert property (
        ce && st_reg == ST_SCAN && modOpt_reg && !modBits[idx_reg]
        |=> st_reg != ST_FETCH)
        else $error("unmodified component stored");
    chk_wr_hold: assert property (
        memWrValid && !memWrReady |=> memWrValid && $stable(memWr))
        else $error("memory write dropped before accepted");
endmodule : compacted_state_save_unit

// file: sim/save_area_mem.sv
// save-area memory and core state source model
module save_area_mem (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // stall control
    input wire logic slow,
    // save-area write port
    input wire logic memWrValid,
    input wire css_pkg::mem_wr_s memWr,
    output logic memWrReady,
    // core state read
    input wire logic [5:0] stateIdx,
    output logic [63:0] stateData
);
    timeunit 1ns;
    timeprecision 100ps;
    import css_pkg::*;
    mem_wr_s wrLog[$];
    logic [1:0] phase;
    // data pattern tied to the component number
    assign stateData = {26'h0, stateIdx, 26'h1555555, stateIdx};
    // accept writes, only every fourth cycle when slow
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            memWrReady <= 1'h0;
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
            memWrReady <= !slow || phase == 2'h3;
            if (memWrValid && memWrReady) begin
                wrLog.push_back(memWr);
            end
        end
    end
endmodule : save_area_mem

// file: sim/compacted_state_save_unit_tb.sv
// self-checking bench for the compacted state save unit
`include "css_regs.svh"
module compacted_state_save_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import css_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, slow = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bLast;
    logic restoreValid = 1'h0;
    restore_s restoreInfo = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic memWrValid, memWrReady, faultPulse;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] stateIdx;
    logic [63:0] stateData;
    mem_wr_s memWr;
    fault_e faultCode;
    int err_count = 0, n_checks = 0, nFault = 0;
    logic [63:0] cIm, cUen, cSen, cArea, cIn, cMod;
    logic [31:0] cCtrl, cMx;
    // clock
    always #12.5 clk = ~clk;
    // units under test and far side
    compacted_state_save_unit dut (.clk(clk), .nrst(nrst), .ce(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .memWrValid(memWrValid), .memWr(memWr), .memWrReady(memWrReady),
        .stateIdx(stateIdx), .stateData(stateData),
        .restoreValid(restoreValid), .restoreInfo(restoreInfo),
        .faultPulse(faultPulse), .faultCode(faultCode));
    save_area_mem mem (.clk(clk), .nrst(nrst), .slow(slow),
        .memWrValid(memWrValid), .memWr(memWr), .memWrReady(memWrReady),
        .stateIdx(stateIdx), .stateData(stateData));
    // count fault pulses
    always @(posedge clk) begin
        if (faultPulse === 1'h1) nFault <= nFault + 1;
    end
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    function automatic logic [7:0] ba(input logic [3:0] i);
        return {2'h0, i, 2'h0};
    endfunction : ba
    function automatic logic [63:0] sd(input logic [5:0] i);
        return {26'h0, i, 26'h1555555, i};
    endfunction : sd
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done) begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                bLast = bresp;
                done = 1;
            end
        end
        bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!done) begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                d = rdata;
                r = rresp;
                done = 1;
            end
        end
        rready <= 1'h0;
    endtask : axi_rd
    task automatic setup();
        logic [31:0] v [15];
        v = '{cCtrl, 32'h0, cMx, cIm[31:0], cIm[63:32], cUen[31:0],
              cUen[63:32], cSen[31:0], cSen[63:32], cArea[31:0],
              cArea[63:32], cIn[31:0], cIn[63:32], cMod[31:0], cMod[63:32]};
        for (int i = 0; i < 15; i++) if (i != 1) axi_wr(ba(4'(i)), v[i]);
    endtask : setup
    task automatic go(input logic sup);
        logic [31:0] s;
        logic [1:0] r;
        s = '0;
        mem.wrLog.delete();
        axi_wr(ba(`CSS_IDX_CMD), {30'h0, sup, 1'h1});
        while (s[1:0] !== 2'h2) axi_rd(ba(`CSS_IDX_STATUS), s, r);
    endtask : go
    task automatic restore(input logic [1:0] c, input logic nr,
                           input logic [63:0] cmp);
        @(posedge clk);
        restoreValid <= 1'h1;
        restoreInfo <= '{c, nr, cArea, cmp};
        @(posedge clk);
        restoreValid <= 1'h0;
    endtask : restore
    // expected write list worked out from the enables and bitmaps
    task automatic check_save(input logic sup, input bit modOpt);
        logic [63:0] m, off;
        mem_wr_s e[$];
        bit dirty, st;
        int n0;
        m = cIm & (sup ? (cUen | cSen) : cUen);
        dirty = cMx !== `CSS_SIMDCS_INIT;
        e.push_back('{cArea + 64'h200, m & (cIn | {62'h0, dirty, 1'h0})});
        e.push_back('{cArea + 64'h208, {1'h1, m[62:0]}});
        off = cArea + 64'h240;
        for (int i = 0; i < 63; i++) begin
            st = m[i] && (cIn[i] || (i == 1 && dirty));
            st = st && !(modOpt && !cMod[i]);
            if (st && i == 0) e.push_back('{cArea, sd(6'(i))});
            if (st && i == 1) begin
                e.push_back('{cArea + 64'hA0, sd(6'(i))});
                e.push_back('{cArea + 64'h18, {`CSS_SIMDCS_MASK, cMx}});
            end
            if (st && i > 1) e.push_back('{off, sd(6'(i))});
            if (i > 1 && m[i]) off = off + 64'h40;
        end
        n0 = nFault;
        go(sup);
        chk(nFault == n0 && faultCode === FLT_NONE,
            "unexpected fault");
        chk(mem.wrLog.size() == e.size(), "write count");
        for (int i = 0; i < e.size(); i++) begin
            chk(i < mem.wrLog.size() && mem.wrLog[i] === e[i],
                "save write");
        end
    endtask : check_save
    task automatic check_fault(input logic [31:0] ctrl,
        input logic [63:0] area, input logic sup, input fault_e exp);
        logic [31:0] s;
        logic [1:0] r;
        int n0;
        cCtrl = ctrl;
        cArea = area;
        setup();
        n0 = nFault;
        go(sup);
        axi_rd(ba(`CSS_IDX_STATUS), s, r);
        chk(nFault == n0 + 1, "fault pulse count");
        chk(faultCode === exp && s[6:4] === exp, "fault code");
        chk(mem.wrLog.size() == 0, "write on fault");
    endtask : check_fault
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0] r;
        chk(faultCode === FLT_NONE && faultPulse === 1'h0, "fault reset");
        axi_rd(ba(`CSS_IDX_SIMDCS), d, r);
        chk(d === `CSS_SIMDCS_INIT && r === `CSS_RESP_OK, "simd status reset");
        axi_rd(ba(`CSS_IDX_CTRL), d, r);
        chk(d === 32'h0, "ctrl reset");
        axi_rd(8'h40, d, r);
        chk(r === `CSS_RESP_ERR && d === 32'h0, "unmapped read");
        axi_wr(8'h40, 32'h0000_0001);
        chk(bLast === `CSS_RESP_ERR, "unmapped write response");
        axi_wr(ba(`CSS_IDX_STATUS), 32'hFFFF_FFFF);
        chk(bLast === `CSS_RESP_OK, "status write response");
        axi_rd(ba(`CSS_IDX_STATUS), d, r);
        chk(d === 32'h0, "status write");
        axi_wr(ba(`CSS_IDX_AREA_HI), 32'hA5C3_0F96);
        axi_rd(ba(`CSS_IDX_AREA_HI), d, r);
        chk(d === 32'hA5C3_0F96, "area readback");
        wstrb <= 4'h3;
        axi_wr(ba(`CSS_IDX_AREA_HI), 32'h1234_5678);
        wstrb <= 4'hF;
        axi_rd(ba(`CSS_IDX_AREA_HI), d, r);
        chk(d === 32'hA5C3_5678, "byte strobe merge");
        axi_rd(ba(`CSS_IDX_CMD), d, r);
        chk(d === 32'h0 && r === `CSS_RESP_OK, "command readback");
    endtask : test_regs
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        test_regs();
        cUen = 64'h4000_0000_0000_00FF;
        cSen = 64'h0000_0000_0000_FF00;
        cIm = 64'hFFFF_FFFF_0000_0F27;
        cIn = 64'h4000_0000_0000_0F21;
        cMod = 64'h0;
        cMx = 32'h0000_1F80;
        check_fault(32'h000, 64'h1_0000, 1'h0, FLT_UD);
        check_fault(32'h008, 64'h1_0000, 1'h1, FLT_UD);
        check_fault(32'h009, 64'h1_0000, 1'h1, FLT_NM);
        check_fault(32'h301, 64'h1_0000, 1'h1, FLT_GP);
        check_fault(32'h001, 64'h1_0008, 1'h0, FLT_GP);
        check_fault(32'h331, 64'h1_0008, 1'h0, FLT_AC);
        check_fault(32'h031, 64'h1_0020, 1'h1, FLT_GP);
        cCtrl = 32'h301;
        cArea = 64'h1_0000;
        setup();
        restore(2'h3, 1'h0, {1'h1, cIm[62:0] & cUen[62:0]});
        check_save(1'h0, 0);
        check_save(1'h0, 0);
        cMx = 32'h0000_1F81;
        slow <= 1'h1;
        setup();
        check_save(1'h0, 0);
        cCtrl = 32'h001;
        cIn = '1;
        cMod = 64'h0000_0000_0000_0A05;
        setup();
        restore(2'h0, 1'h0, {1'h1, cIm[62:0] & (cUen[62:0] | cSen[62:0])});
        check_save(1'h1, 1);
        slow <= 1'h0;
        restore(2'h0, 1'h1, {1'h1, cIm[62:0] & (cUen[62:0] | cSen[62:0])});
        check_save(1'h1, 0);
        tally_and_finish();
    end
    // watchdog against a hang
    initial begin
        #1000000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : compacted_state_save_unit_tb
